// ==== ofc_defines.svh ====
// Offsets, field positions, reset values and timing counts of the clock control block.
// Assumes a Wishbone slave with byte addresses in the low eight address bits.
`ifndef OFC_DEFINES_SVH
`define OFC_DEFINES_SVH

`define OFC_ADDR_W          8
`define OFC_OFF_OSC         8'h20
`define OFC_OFF_LOOP        8'h24
`define OFC_OFF_TRIM        8'h28
`define OFC_OFF_STATUS      8'h30

`define OFC_RST_OSC         32'h0000_0382
`define OFC_RST_LOOP        32'h0000_0080

`define OFC_B_ENABLE        1
`define OFC_B_MODE          2
`define OFC_B_STABLE        3
`define OFC_B_WAKEDROP      4
`define OFC_B_STDBY         6
`define OFC_B_ONREQ         7
`define OFC_B_CCOFF         8
`define OFC_B_QLOFF         9
`define OFC_PSEL_LO         8
`define OFC_PSEL_HI         9
`define OFC_FINE_HI         9
`define OFC_COARSE_LO       10
`define OFC_COARSE_HI       15

`define OFC_NREQ            4
`define OFC_LOOP_SYNC       3
`define OFC_PIN_SYNC        2

`endif

// ==== ofc_pkg.sv ====
// Types shared by the clock control block.
// Assumes ofc_defines.svh is on the include path.
package ofc_pkg;
  typedef enum logic [1:0] {
    OFC_LOOP_OFF,
    OFC_LOOP_RUN,
    OFC_LOOP_SLEPT
  } ofc_loop_e;
  typedef logic [5:0] ofc_coarse_t;
  typedef logic [9:0] ofc_fine_t;
endpackage : ofc_pkg

// ==== ofc_sync.sv ====
// Flip-flop delay chain: pin synchroniser or fixed synchronisation delay.
// Assumes one clock; the first stage is read only by the second.
module ofc_sync #(
  parameter int W      = 1,
  parameter int STAGES = 2
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] stage_reg [STAGES];
  logic [W-1:0] stage_next [STAGES];

  always_comb begin
    stage_next[0] = i_d;
    for (int k = 1; k < STAGES; k++) begin
      stage_next[k] = stage_reg[k-1];
    end
  end

  genvar g;
  generate
    for (g = 0; g < STAGES; g++) begin : g_stage
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          stage_reg[g] <= '0;
        end else begin
          stage_reg[g] <= stage_next[g];
        end
      end
    end
  endgenerate

  assign o_q = stage_reg[STAGES-1];
endmodule : ofc_sync

// ==== ofc_clock_ctrl.sv ====
// Clock source control: 8 MHz oscillator and frequency locked loop enables and trims.
// Assumes a classic Wishbone master, request lines and standby on i_clk,
// and analog ready/lock levels arriving asynchronously.
`include "ofc_defines.svh"

// Behaviour
// - Prescale code 0,1,2,3 divides oscillator ticks by 1,2,4,8.
// - On-request-run set: oscillator runs only while some peripheral requests it.
// - On-request-run clear: enabled oscillator runs continuously.
// - Standby with keep-running clear stops the 8 MHz oscillator.
// - Standby with keep-running set keeps normal on-request or continuous running.
// - Enable bit reads one when running or stopping, zero when stopped or starting.
// - Quick lock used unless quick-lock-off bit 9 is set.
// - Chill cycles done unless chill-cycle-off bit 8 is set.
// - Loop stopped in sleep drops lock on wake when bit 4 set.
// - Bit 3 set freezes fine trim after fine lock; else it tracks.
// - Mode bit 2 clear is open loop, set is closed loop.
// - Loop in standby runs only with its keep-running bit set.
// - Loop enable reads back at once; takes effect after synchronisation delay.
// - Closed loop makes coarse and fine trims read only, hardware updated.
module ofc_clock_ctrl
  import ofc_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_rstn,
  input  wire logic                   i_wb_cyc,
  input  wire logic                   i_wb_stb,
  input  wire logic                   i_wb_we,
  input  wire logic [`OFC_ADDR_W-1:0] i_wb_adr,
  input  wire logic [3:0]             i_wb_sel,
  input  wire logic [31:0]            i_wb_dat,
  output logic      [31:0]            o_wb_dat,
  output logic                        o_wb_ack,
  input  wire logic [`OFC_NREQ-1:0]   i_osc_req,
  input  wire logic [`OFC_NREQ-1:0]   i_loop_req,
  input  wire logic                   i_standby,
  input  wire logic                   i_osc_tick,
  input  wire logic                   i_osc_ready,
  input  wire logic                   i_loop_ready,
  input  wire logic                   i_loop_coarse_lock,
  input  wire logic                   i_loop_fine_lock,
  input  wire logic                   i_loop_trim_valid,
  input  wire logic [5:0]             i_loop_coarse,
  input  wire logic [9:0]             i_loop_fine,
  output logic                        o_osc_run,
  output logic                        o_osc_div_en,
  output logic                        o_loop_run,
  output logic                        o_loop_quick_lock_en,
  output logic                        o_loop_chill_en,
  output logic                        o_loop_closed,
  output logic                        o_loop_fine_hold,
  output logic      [5:0]             o_loop_coarse,
  output logic      [9:0]             o_loop_fine
);

  function automatic logic run_decision(input logic en, input logic onreq,
                                        input logic stdby_keep, input logic standby,
                                        input logic req);
    logic demand;
    demand = onreq ? req : 1'b1;
    run_decision = en && demand && (!standby || stdby_keep);
  endfunction : run_decision

  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    merge_lanes = m;
  endfunction : merge_lanes

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers and enable delay

  logic [3:0] pins_sync;
  logic       loop_en_eff;
  logic [31:0] osc_reg;
  logic [31:0] osc_next;
  logic [31:0] loop_reg;
  logic [31:0] loop_next;

  ofc_sync #(.W(4), .STAGES(`OFC_PIN_SYNC)) u_pin_sync (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_d    ({i_loop_fine_lock, i_loop_coarse_lock, i_loop_ready, i_osc_ready}),
    .o_q    (pins_sync)
  );

  // Loop start and stop lag the written enable, which reads back at once.
  ofc_sync #(.W(1), .STAGES(`OFC_LOOP_SYNC)) u_loop_en (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_d    (loop_reg[`OFC_B_ENABLE]),
    .o_q    (loop_en_eff)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request, write at the ack edge

  logic        ack_reg;
  logic        ack_next;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;
  logic        wr_go;
  ofc_coarse_t coarse_reg;
  ofc_coarse_t coarse_next;
  ofc_fine_t   fine_reg;
  ofc_fine_t   fine_next;
  logic        clock_lock_reg;
  logic        clock_lock_next;
  logic        fine_lock_reg;
  logic        fine_lock_next;

  assign wr_go = i_wb_cyc && i_wb_stb && i_wb_we && ack_reg;

  always_comb begin
    ack_next  = i_wb_cyc && i_wb_stb && !ack_reg;
    rdat_next = rdat_reg;
    if (ack_next) begin
      case (i_wb_adr)
        `OFC_OFF_OSC: begin
          rdat_next = osc_reg & 32'h0000_03c2;
          rdat_next[`OFC_B_ENABLE] = pins_sync[0];
        end
        `OFC_OFF_LOOP:   rdat_next = loop_reg & 32'h0000_03de;
        `OFC_OFF_TRIM:   rdat_next = {16'h0000, coarse_reg, fine_reg};
        `OFC_OFF_STATUS: rdat_next = {27'h0000000, loop_en_eff, fine_lock_reg,
                                      clock_lock_reg, pins_sync[1], pins_sync[0]};
        default:         rdat_next = 32'h0000_0000; // Unmapped reads zero, writes dropped
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg  <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdat_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_comb begin
    osc_next  = osc_reg;
    loop_next = loop_reg;
    if (wr_go && i_wb_adr == `OFC_OFF_OSC) begin
      osc_next = merge_lanes(osc_reg, i_wb_dat, i_wb_sel) & 32'h0000_03c2;
    end
    if (wr_go && i_wb_adr == `OFC_OFF_LOOP) begin
      loop_next = merge_lanes(loop_reg, i_wb_dat, i_wb_sel) & 32'h0000_03de;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      osc_reg  <= `OFC_RST_OSC;
      loop_reg <= `OFC_RST_LOOP;
    end else begin
      osc_reg  <= osc_next;
      loop_reg <= loop_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run decisions and prescaler

  logic osc_req_any;
  logic loop_req_any;
  logic [2:0] tick_cnt_reg;
  logic [2:0] tick_cnt_next;
  logic [2:0] div_mask;
  logic       div_en_next;
  logic       div_en_reg;

  assign osc_req_any  = |i_osc_req;
  assign loop_req_any = |i_loop_req;
  assign o_osc_run = run_decision(osc_reg[`OFC_B_ENABLE], osc_reg[`OFC_B_ONREQ],
                                  osc_reg[`OFC_B_STDBY], i_standby, osc_req_any);
  assign o_loop_run  = run_decision(loop_en_eff, loop_reg[`OFC_B_ONREQ],
                                    loop_reg[`OFC_B_STDBY], i_standby, loop_req_any);
  always_comb begin
    case (osc_reg[`OFC_PSEL_HI:`OFC_PSEL_LO])
      2'h0:    div_mask = 3'h0;
      2'h1:    div_mask = 3'h1;
      2'h2:    div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
    tick_cnt_next = tick_cnt_reg;
    div_en_next   = 1'b0;
    if (!o_osc_run) begin
      tick_cnt_next = 3'h0;
    end else if (i_osc_tick) begin
      div_en_next   = ((tick_cnt_reg & div_mask) == 3'h0);
      tick_cnt_next = tick_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_cnt_reg <= 3'h0;
      div_en_reg   <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      div_en_reg   <= div_en_next;
    end
  end

  assign o_osc_div_en = div_en_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Loop options, lock tracking across sleep, trims

  ofc_loop_e state_reg;
  ofc_loop_e state_next;
  logic      lock_drop;
  logic      clock_seen_reg;
  logic      fine_seen_reg;
  logic      clock_rise;
  logic      fine_rise;
  logic      trim_wr;
  logic      fine_frozen;

  assign o_loop_quick_lock_en = !loop_reg[`OFC_B_QLOFF];
  assign o_loop_chill_en      = !loop_reg[`OFC_B_CCOFF];
  assign o_loop_closed        = loop_reg[`OFC_B_MODE];
  assign clock_rise = pins_sync[2] && !clock_seen_reg;
  assign fine_rise  = pins_sync[3] && !fine_seen_reg;
  assign trim_wr    = wr_go && i_wb_adr == `OFC_OFF_TRIM;
  assign fine_frozen = loop_reg[`OFC_B_STABLE] && fine_lock_reg;

  always_comb begin
    state_next = state_reg;
    lock_drop  = 1'b0;
    case (state_reg)
      OFC_LOOP_OFF:   if (o_loop_run) state_next = OFC_LOOP_RUN;
      OFC_LOOP_RUN: begin
        if (!loop_en_eff) begin
          state_next = OFC_LOOP_OFF;
          lock_drop  = 1'b1;
        end else if (!o_loop_run && i_standby) begin
          state_next = OFC_LOOP_SLEPT;
        end
      end
      OFC_LOOP_SLEPT: begin
        if (!i_standby) begin
          state_next = o_loop_run ? OFC_LOOP_RUN : OFC_LOOP_OFF;
          lock_drop  = loop_reg[`OFC_B_WAKEDROP];
        end
      end
      default:        state_next = OFC_LOOP_OFF;
    endcase
    // A lock that rises while it is being dropped is kept
    clock_lock_next = clock_rise || (clock_lock_reg && !lock_drop);
    fine_lock_next  = fine_rise || (fine_lock_reg && !lock_drop);
    coarse_next = coarse_reg;
    fine_next   = fine_reg;
    if (loop_reg[`OFC_B_MODE]) begin
      if (i_loop_trim_valid) begin
        coarse_next = i_loop_coarse;
        if (!fine_frozen) begin
          fine_next = i_loop_fine;
        end
      end
    end else if (trim_wr) begin
      coarse_next = ofc_coarse_t'(i_wb_dat[`OFC_COARSE_HI:`OFC_COARSE_LO]);
      fine_next   = ofc_fine_t'(i_wb_dat[`OFC_FINE_HI:0]);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg      <= OFC_LOOP_OFF;
      clock_lock_reg <= 1'b0;
      fine_lock_reg  <= 1'b0;
      clock_seen_reg <= 1'b0;
      fine_seen_reg  <= 1'b0;
      coarse_reg     <= '0;
      fine_reg       <= '0;
    end else begin
      state_reg      <= state_next;
      clock_lock_reg <= clock_lock_next;
      fine_lock_reg  <= fine_lock_next;
      clock_seen_reg <= pins_sync[2];
      fine_seen_reg  <= pins_sync[3];
      coarse_reg     <= coarse_next;
      fine_reg       <= fine_next;
    end
  end

  assign o_loop_fine_hold = fine_frozen;
  assign o_loop_coarse    = coarse_reg;
  assign o_loop_fine      = fine_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_lock_wake;
    state_reg == OFC_LOOP_SLEPT && !i_standby && loop_reg[`OFC_B_WAKEDROP];
  endsequence
  a_div_no_burst: assert property (
    o_osc_div_en && osc_reg[`OFC_PSEL_HI:`OFC_PSEL_LO] != 2'h0 && $stable(osc_reg)
      |=> !o_osc_div_en)
    else $error("divided enable came on two cycles in a row");
  a_onreq_idle: assert property (
    osc_reg[`OFC_B_ONREQ] && i_osc_req == '0 |-> !o_osc_run)
    else $error("oscillator runs with no request");
  a_always_run: assert property (
    osc_reg[`OFC_B_ENABLE] && !osc_reg[`OFC_B_ONREQ] && !i_standby |-> o_osc_run)
    else $error("enabled oscillator not running");
  a_osc_standby_off: assert property (
    i_standby && !osc_reg[`OFC_B_STDBY] |-> !o_osc_run)
    else $error("oscillator runs in standby");
  a_loop_standby_off: assert property (
    i_standby && !loop_reg[`OFC_B_STDBY] |-> !o_loop_run)
    else $error("loop runs in standby");
  a_loop_en_lag: assert property (
    ##3 (loop_en_eff == $past(loop_reg[`OFC_B_ENABLE], 3)))
    else $error("loop enable delay wrong");
  a_loop_readback: assert property (
    wr_go && i_wb_adr == `OFC_OFF_LOOP && i_wb_sel[0]
      |=> loop_reg[`OFC_B_ENABLE] == $past(i_wb_dat[`OFC_B_ENABLE]))
    else $error("loop enable not written at once");
  a_trim_ro: assert property (
    loop_reg[`OFC_B_MODE] && trim_wr && !i_loop_trim_valid |=> $stable(coarse_reg))
    else $error("trim written in closed loop");
  a_fine_hold: assert property (
    loop_reg[`OFC_B_MODE] && fine_frozen |=> $stable(fine_reg))
    else $error("fine trim moved after lock");
  a_lock_wake: assert property (
    s_lock_wake ##0 !clock_rise |=> !clock_lock_reg)
    else $error("lock kept after wake");
endmodule : ofc_clock_ctrl

// ==== ofc_far_model.sv ====
// Far-side model: analog cores of both sources, giving tick, ready, lock and trims.
// Assumes the run levels of the control block and one shared clock.
module ofc_far_model (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_osc_run,
  input  wire logic       i_loop_run,
  input  wire logic       i_lock_on,
  output logic            o_tick,
  output logic            o_osc_ready,
  output logic            o_loop_ready,
  output logic            o_lock,
  output logic            o_trim_valid,
  output logic      [5:0] o_coarse,
  output logic      [9:0] o_fine
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] osc_sh_reg;
  logic [3:0] loop_sh_reg;
  logic [1:0] ph_reg;
  // Ready lags run by four cycles so that starting and stopping phases are visible
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      osc_sh_reg <= 4'h0;
      loop_sh_reg <= 4'h0;
      ph_reg <= 2'h0;
      o_coarse <= 6'h00;
      o_fine <= 10'h000;
    end else begin
      osc_sh_reg <= {osc_sh_reg[2:0], i_osc_run};
      loop_sh_reg <= {loop_sh_reg[2:0], i_loop_run};
      ph_reg <= ph_reg + 2'h1;
      if (i_loop_run && ph_reg == 2'h3) begin
        o_coarse <= o_coarse + 6'h01;
        o_fine <= o_fine + 10'h003;
      end
    end
  end
  assign o_tick = i_osc_run & ph_reg[0];
  assign o_osc_ready = osc_sh_reg[3];
  assign o_loop_ready = loop_sh_reg[3];
  assign o_lock = i_lock_on;
  assign o_trim_valid = i_loop_run & (ph_reg == 2'h0);
endmodule : ofc_far_model

// ==== tb_ofc_clock_ctrl.sv ====
// Self-checking bench of the clock control block over classic Wishbone.
// Assumes ofc_defines.svh on the include path and the far-side model.
`include "ofc_defines.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_ofc_clock_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, rstn, wb_cyc, wb_stb, wb_we, standby, lock_on, tick, osc_rdy, loop_rdy;
  logic lock, tvalid, o_wb_ack, o_osc_run, o_osc_div_en, o_loop_run;
  logic o_ql, o_cc, o_closed, o_fh;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel, osc_req, loop_req;
  logic [31:0] wb_dat, o_wb_dat, q;
  logic [5:0]  m_coarse, o_loop_coarse;
  logic [9:0]  m_fine, o_loop_fine, f;
  int          err_total, cmp_count, cyc_cnt, c;
  ofc_clock_ctrl i_ofc_clock_ctrl (.i_clk(i_clk), .i_rstn(rstn), .i_wb_cyc(wb_cyc),
    .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel),
    .i_wb_dat(wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_osc_req(osc_req),
    .i_loop_req(loop_req), .i_standby(standby), .i_osc_tick(tick), .i_osc_ready(osc_rdy),
    .i_loop_ready(loop_rdy), .i_loop_coarse_lock(lock), .i_loop_fine_lock(lock),
    .i_loop_trim_valid(tvalid), .i_loop_coarse(m_coarse), .i_loop_fine(m_fine),
    .o_osc_run(o_osc_run), .o_osc_div_en(o_osc_div_en), .o_loop_run(o_loop_run),
    .o_loop_quick_lock_en(o_ql), .o_loop_chill_en(o_cc), .o_loop_closed(o_closed),
    .o_loop_fine_hold(o_fh), .o_loop_coarse(o_loop_coarse), .o_loop_fine(o_loop_fine));
  ofc_far_model i_ofc_far_model (.i_clk(i_clk), .i_rstn(rstn), .i_osc_run(o_osc_run),
    .i_loop_run(o_loop_run), .i_lock_on(lock_on), .o_tick(tick), .o_osc_ready(osc_rdy),
    .o_loop_ready(loop_rdy), .o_lock(lock), .o_trim_valid(tvalid), .o_coarse(m_coarse),
    .o_fine(m_fine));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // Hang guard: the whole sequence needs well under two thousand cycles
  always @(posedge i_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 6000) begin
      err_total++;
      results();
    end
  end
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge i_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    q = o_wb_dat;
    if (n >= 20) err_total++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb
  task automatic tk(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tk
  // Software side polls until the enable state has settled before toggling it
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n = 0;
    do begin
      wb(1'b0, a, 32'h0);
      n++;
    end while ((q & m) !== v && n < 30);
    `CHK(q & m, v)
  endtask : poll
  task automatic gap;
    c = 0;
    do begin
      @(posedge i_clk);
      c++;
    end while (o_osc_div_en !== 1'b1 && c < 100);
  endtask : gap
  initial begin
    logic [31:0] tv [4] = '{32'h2, 32'h42, 32'hc2, 32'hc2};
    logic [3:0]  tr [4] = '{4'h0, 4'h0, 4'h0, 4'h2};
    logic        te [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    rstn = 1'b0;
    {wb_cyc, wb_stb, wb_we, standby, lock_on} = 5'h00;
    wb_adr = 8'h00;
    wb_sel = 4'hf;
    wb_dat = 32'h0;
    osc_req = 4'h0;
    loop_req = 4'h0;
    repeat (8) @(posedge i_clk);
    rstn <= 1'b1;
    wb(1'b0, `OFC_OFF_LOOP, 32'h0);
    `CHK(q, 32'h0000_0080)
    wb(1'b0, `OFC_OFF_OSC, 32'h0);
    `CHK(q, 32'h0000_0380)
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clk);
      osc_req <= 4'h1 << i;
      tk(1);
      `CHK(o_osc_run, 1'b1)
    end
    @(posedge i_clk);
    osc_req <= 4'h0;
    tk(1);
    `CHK(o_osc_run, 1'b0)
    wb(1'b1, `OFC_OFF_OSC, 32'h2);
    tk(1);
    `CHK(o_osc_run, 1'b1)
    poll(`OFC_OFF_OSC, 32'h2, 32'h2);
    wb(1'b1, `OFC_OFF_OSC, 32'h0);
    wb(1'b0, `OFC_OFF_OSC, 32'h0);
    `CHK(q & 32'h2, 32'h2)
    poll(`OFC_OFF_OSC, 32'h2, 32'h0);
    @(posedge i_clk);
    standby <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, `OFC_OFF_OSC, tv[i]);
      osc_req <= tr[i];
      tk(2);
      `CHK(o_osc_run, te[i])
    end
    @(posedge i_clk);
    standby <= 1'b0;
    osc_req <= 4'h0;
    for (int p = 0; p < 4; p++) begin
      wb(1'b1, `OFC_OFF_OSC, (p << 8) | 32'h2);
      repeat (3) gap();
      `CHK(c, 2 << p)
    end
    wb(1'b1, `OFC_OFF_LOOP, 32'h030c);
    tk(1);
    `CHK({o_ql, o_cc, o_closed}, 3'b001)
    wb(1'b1, `OFC_OFF_LOOP, 32'h0000);
    tk(1);
    `CHK({o_ql, o_cc, o_closed}, 3'b110)
    wb(1'b1, `OFC_OFF_LOOP, 32'h0002);
    #1;
    `CHK(o_loop_run, 1'b0)
    wb(1'b0, `OFC_OFF_LOOP, 32'h0);
    `CHK(q, 32'h0000_0002)
    tk(2);
    `CHK(o_loop_run, 1'b1)
    wb(1'b1, `OFC_OFF_TRIM, 32'ha5c3);
    wb(1'b0, `OFC_OFF_TRIM, 32'h0);
    `CHK(q, 32'h0000_a5c3)
    // Closed loop: software trim write must lose to hardware tracking
    wb(1'b1, `OFC_OFF_LOOP, 32'h0006);
    wb(1'b1, `OFC_OFF_TRIM, 32'h0);
    tk(6);
    // The model shows a new trim a cycle before the block takes it
    if (tvalid) tk(1);
    `CHK({o_loop_coarse, o_loop_fine}, {m_coarse, m_fine})
    `CHK(o_fh, 1'b0)
    wb(1'b1, `OFC_OFF_LOOP, 32'h000e);
    lock_on <= 1'b1;
    tk(8);
    f = o_loop_fine;
    tk(13);
    if (tvalid) tk(1);
    `CHK(o_loop_fine, f)
    `CHK(o_fh, 1'b1)
    `CHK(o_loop_coarse, m_coarse)
    for (int l = 1; l >= 0; l--) begin
      wb(1'b1, `OFC_OFF_LOOP, 32'h0002 | (l << 4));
      lock_on <= 1'b0;
      repeat (4) @(posedge i_clk);
      lock_on <= 1'b1;
      tk(8);
      wb(1'b0, `OFC_OFF_STATUS, 32'h0);
      `CHK(q & 32'hc, 32'hc)
      standby <= 1'b1;
      tk(6);
      `CHK(o_loop_run, 1'b0)
      @(posedge i_clk);
      standby <= 1'b0;
      tk(4);
      wb(1'b0, `OFC_OFF_STATUS, 32'h0);
      `CHK(q & 32'hc, (l != 0) ? 32'h0 : 32'hc)
    end
    // Loop on request: runs only while some peripheral asks for it
    wb(1'b1, `OFC_OFF_LOOP, 32'h0082);
    tk(1);
    `CHK(o_loop_run, 1'b0)
    @(posedge i_clk);
    loop_req <= 4'h8;
    tk(1);
    `CHK(o_loop_run, 1'b1)
    @(posedge i_clk);
    loop_req <= 4'h0;
    tk(1);
    `CHK(o_loop_run, 1'b0)
    wb(1'b1, 8'h3c, 32'hffff_ffff);
    wb(1'b0, 8'h3c, 32'h0);
    `CHK(q, 32'h0)
    results();
  end
endmodule : tb_ofc_clock_ctrl
